/* File: rtl/frspd_pkg.sv */
// shared constants, timing counts and sector decode for the flash control block
package frspd_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam int HI_W = 6;
   localparam int SEC_W = 7;
   localparam int SEC_MSB = 21;
   localparam int SEC_LSB = 15;
   localparam int MEM_AW = 6;
   // timing in ns; only the 60 ns sleep extension is fixed, the rest are plain defaults
   localparam int ACCESS_TIME_NS = 90;
   localparam int SLEEP_EXTRA_NS = 60;
   localparam int RESET_PULSE_WIDTH_NS = 500;
   localparam int RESET_HIGH_RECOVERY_NS = 200;
   localparam int READY_EMBEDDED_NS = 20000;
   localparam int READY_IDLE_NS = 500;
   localparam int PROGRAM_TIME_NS = 1000;
   localparam int ERASE_TIME_NS = 4000;
   localparam int WE_LOW_NS = 20;
   // least times round up
   localparam int ACC_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SLEEP_CYC = (ACCESS_TIME_NS + SLEEP_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RP_CYC = (RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RH_CYC = (RESET_HIGH_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READY_EA_CYC = (READY_EMBEDDED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READY_CYC = (READY_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PROG_CYC = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_CYC = ACC_CYC + 2;
   localparam int CNT_W = 16;
   // command sequence
   localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
   localparam logic [11:0] UNLOCK_ADDR2 = 12'h2AA;
   localparam logic [7:0] UNLOCK_DATA1 = 8'hAA;
   localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
   localparam logic [7:0] CMD_PROGRAM = 8'hA0;
   localparam logic [7:0] CMD_ERASE = 8'h80;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] CMD_LOCK = 8'h60;
   localparam logic [7:0] CMD_UNLOCK = 8'h61;
   localparam logic [6:0] SEC_FIRST = 7'h00;
   localparam logic [6:0] SEC_LAST = 7'h7F;
   localparam logic [6:0] BANK_B_SECTORS = 7'h60;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;

   typedef enum logic [2:0] {
      DEV_READ = 3'b000, DEV_C1 = 3'b001, DEV_C2 = 3'b011, DEV_PROG = 3'b010,
      DEV_E1 = 3'b110, DEV_E2 = 3'b111, DEV_E3 = 3'b101, DEV_BUSY = 3'b100
   } frspd_dev_state_t;

   typedef enum logic [2:0] {
      HST_IDLE = 3'b000, HST_ADDR = 3'b001, HST_WR = 3'b011, HST_RD = 3'b010,
      HST_GAP = 3'b110, HST_RST = 3'b111, HST_REC = 3'b101
   } frspd_host_state_t;

   function automatic logic [SEC_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
      return a[SEC_MSB:SEC_LSB];
   endfunction : sector_of

   function automatic logic in_bank_b(input logic [ADDR_W-1:0] a);
      return sector_of(a) < BANK_B_SECTORS;
   endfunction : in_bank_b
endpackage : frspd_pkg

/* File: rtl/frspd_if.sv */
// multiplexed address/data flash bus between host controller and flash control end
`timescale 1ns/100ps
interface frspd_if;
   logic [15:0] host_adq_o;
   logic host_adq_oe;
   logic [15:0] dev_adq_o;
   logic dev_adq_oe;
   logic [15:0] adq;
   logic [5:0] addr_hi;
   logic avd_n;
   logic ce_n;
   logic we_n;
   logic oe_n;
   logic reset_n;

   // undriven bus floats high, modelled as a pull-up
   assign adq = host_adq_oe ? host_adq_o : (dev_adq_oe ? dev_adq_o : 16'hFFFF);

   modport dev (input adq, addr_hi, avd_n, ce_n, we_n, oe_n, reset_n, output dev_adq_o, dev_adq_oe);
   modport host (input adq, output host_adq_o, host_adq_oe, addr_hi, avd_n, ce_n, we_n, oe_n, reset_n);
endinterface : frspd_if

/* File: rtl/frspd_device.sv */
// flash end: sleep, hardware reset, output disable, write gating, sector protection and decode
`timescale 1ns/100ps
module frspd_device
   import frspd_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   frspd_if.dev bus,
   input wire logic wp_n,
   input wire logic vpp_n,
   input wire logic supply_low,
   output logic sleep,
   output logic busy,
   output logic ready,
   output logic prot_refused,
   output logic [frspd_pkg::SEC_W-1:0] sector_index,
   output logic bank_b
);
   logic [1:0] wp_sync_reg, vpp_sync_reg, low_sync_reg;
   logic wp_s, vpp_s, low_s;
   logic [ADDR_W-1:0] addr_reg;
   logic [CNT_W-1:0] stable_cnt_reg;
   logic [DATA_W-1:0] dq_reg;
   logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];
   logic [CNT_W-1:0] rst_low_cnt_reg;
   logic rst_taken_reg;
   logic was_busy_reg;
   logic [CNT_W-1:0] ready_cnt_reg;
   logic armed_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic [(1<<SEC_W)-1:0] lock_reg;
   frspd_dev_state_t state_reg;
   logic [CNT_W-1:0] busy_cnt_reg;
   logic prot_refused_reg;
   logic wr_evt, addr_latch, bus_free, op_start, sec_locked;
   logic is_unl1, is_unl2, do_prog, do_erase;

   // user-side straps arrive asynchronously
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wp_sync_reg <= 2'b11;
         vpp_sync_reg <= 2'b11;
         low_sync_reg <= 2'b00;
      end else begin
         wp_sync_reg <= {wp_sync_reg[0], wp_n};
         vpp_sync_reg <= {vpp_sync_reg[0], vpp_n};
         low_sync_reg <= {low_sync_reg[0], supply_low};
      end
   end
   assign wp_s = wp_sync_reg[1];
   assign vpp_s = vpp_sync_reg[1];
   assign low_s = low_sync_reg[1];

   // bus is deaf while reset pin is low
   assign bus_free = bus.reset_n;
   assign addr_latch = bus_free && !bus.avd_n && !bus.ce_n;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         addr_reg <= '0;
      end else if (addr_latch) begin
         addr_reg <= {bus.addr_hi, bus.adq};
      end
   end

   // only a newly latched address that differs restarts the access; oe_n and we_n play no part
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stable_cnt_reg <= '0;
      end else if (addr_latch && ({bus.addr_hi, bus.adq} != addr_reg)) begin
         stable_cnt_reg <= '0;
      end else if (stable_cnt_reg != CNT_W'(SLEEP_CYC)) begin
         stable_cnt_reg <= stable_cnt_reg + 1'b1;
      end
   end
   assign sleep = (stable_cnt_reg == CNT_W'(SLEEP_CYC));

   // word appears one access time after the address; sleep never disturbs it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dq_reg <= '0;
      end else if (stable_cnt_reg == CNT_W'(ACC_CYC - 1)) begin
         dq_reg <= mem[addr_reg[MEM_AW-1:0]];
      end
   end

   assign bus.dev_adq_o = dq_reg;
   assign bus.dev_adq_oe = bus_free && !rst_taken_reg && !bus.ce_n && !bus.oe_n && bus.we_n && bus.avd_n;

   // reset pin qualification: short pulses mute the bus and ready but leave the sequencer and lock bits alone
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rst_low_cnt_reg <= '0;
         rst_taken_reg <= 1'b0;
      end else if (bus.reset_n) begin
         rst_low_cnt_reg <= '0;
         rst_taken_reg <= 1'b0;
      end else if (rst_low_cnt_reg != CNT_W'(RP_CYC)) begin
         rst_low_cnt_reg <= rst_low_cnt_reg + 1'b1;
      end else begin
         rst_taken_reg <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         was_busy_reg <= 1'b0;
         ready_cnt_reg <= '0;
      end else if (!bus.reset_n) begin
         if (rst_low_cnt_reg == CNT_W'(RP_CYC) && !rst_taken_reg) begin
            was_busy_reg <= (state_reg == DEV_BUSY);
         end
         ready_cnt_reg <= '0;
      end else if (rst_taken_reg) begin
         ready_cnt_reg <= was_busy_reg ? CNT_W'(READY_EA_CYC) : CNT_W'(READY_CYC);
      end else if (ready_cnt_reg != '0) begin
         ready_cnt_reg <= ready_cnt_reg - 1'b1;
      end
   end
   assign ready = bus.reset_n && !rst_taken_reg && (ready_cnt_reg == '0);

   // write cycle armed only with select and strobe low and output enable high
   always_ff @(posedge core_clk) begin
      if (rst) begin
         armed_reg <= 1'b0;
         wdata_reg <= '0;
      end else if (bus_free && !low_s && !bus.ce_n && !bus.we_n && bus.oe_n && bus.avd_n) begin
         armed_reg <= 1'b1;
         wdata_reg <= bus.adq;
      end else if (!bus.we_n && (bus.ce_n || !bus.oe_n)) begin
         armed_reg <= 1'b0;
      end else if (bus.we_n || !bus_free || low_s) begin
         armed_reg <= 1'b0;
      end
   end
   // data taken as the strobe rises
   assign wr_evt = armed_reg && bus.we_n && bus_free && !low_s;

   assign sector_index = sector_of(addr_reg);
   assign bank_b = in_bank_b(addr_reg);
   assign sec_locked = lock_reg[sector_index]
      || (!wp_s && (sector_index == SEC_FIRST || sector_index == SEC_LAST))
      || !vpp_s;
   assign is_unl1 = addr_reg[11:0] == UNLOCK_ADDR1 && wdata_reg[7:0] == UNLOCK_DATA1;
   assign is_unl2 = addr_reg[11:0] == UNLOCK_ADDR2 && wdata_reg[7:0] == UNLOCK_DATA2;
   assign do_prog = wr_evt && state_reg == DEV_PROG && !sec_locked;
   assign do_erase = wr_evt && state_reg == DEV_E3 && wdata_reg[7:0] == CMD_SECTOR_ERASE && !sec_locked;
   assign op_start = do_prog || do_erase;

   // command sequencer; any wrong step falls back to array read
   always_ff @(posedge core_clk) begin
      if (rst || rst_taken_reg || low_s) begin
         state_reg <= DEV_READ;
         busy_cnt_reg <= '0;
      end else if (state_reg == DEV_BUSY) begin
         if (busy_cnt_reg == '0) begin
            state_reg <= DEV_READ;
         end else begin
            busy_cnt_reg <= busy_cnt_reg - 1'b1;
         end
      end else if (wr_evt) begin
         unique case (state_reg)
            DEV_READ: state_reg <= is_unl1 ? DEV_C1 : DEV_READ;
            DEV_C1: state_reg <= is_unl2 ? DEV_C2 : DEV_READ;
            DEV_C2: begin
               if (wdata_reg[7:0] == CMD_PROGRAM) begin
                  state_reg <= DEV_PROG;
               end else if (wdata_reg[7:0] == CMD_ERASE) begin
                  state_reg <= DEV_E1;
               end else begin
                  state_reg <= DEV_READ;
               end
            end
            DEV_E1: state_reg <= is_unl1 ? DEV_E2 : DEV_READ;
            DEV_E2: state_reg <= is_unl2 ? DEV_E3 : DEV_READ;
            DEV_PROG, DEV_E3: begin
               state_reg <= op_start ? DEV_BUSY : DEV_READ;
               busy_cnt_reg <= do_prog ? CNT_W'(PROG_CYC - 1) : CNT_W'(ERASE_CYC - 1);
            end
            DEV_BUSY: state_reg <= DEV_BUSY;
         endcase
      end
   end
   assign busy = (state_reg == DEV_BUSY);

   // lock bits survive the reset pin; only core reset or an unlock command for the sector clears them
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lock_reg <= '0;
      end else if (wr_evt && state_reg == DEV_C2 && !low_s) begin
         if (wdata_reg[7:0] == CMD_LOCK) begin
            lock_reg[sector_index] <= 1'b1;
         end else if (wdata_reg[7:0] == CMD_UNLOCK) begin
            lock_reg[sector_index] <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         prot_refused_reg <= 1'b0;
      end else begin
         prot_refused_reg <= wr_evt && sec_locked && (state_reg == DEV_PROG ||
            (state_reg == DEV_E3 && wdata_reg[7:0] == CMD_SECTOR_ERASE));
      end
   end
   assign prot_refused = prot_refused_reg;

   // small window of the array; erase clears the whole window for brevity
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < (1 << MEM_AW); i++) begin
            mem[i] <= ERASED_WORD;
         end
      end else if (do_prog) begin
         mem[addr_reg[MEM_AW-1:0]] <= mem[addr_reg[MEM_AW-1:0]] & wdata_reg;
      end else if (do_erase) begin
         for (int i = 0; i < (1 << MEM_AW); i++) begin
            mem[i] <= ERASED_WORD;
         end
      end
   end
endmodule : frspd_device

/* File: rtl/frspd_host.sv */
// host controller end: single read/write bus cycles and hardware reset pulse generation
`timescale 1ns/100ps
module frspd_host
   import frspd_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   frspd_if.host bus,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [frspd_pkg::ADDR_W-1:0] req_addr,
   input wire logic [frspd_pkg::DATA_W-1:0] req_data,
   output logic req_ready,
   input wire logic reset_req,
   output logic rsp_valid,
   output logic [frspd_pkg::DATA_W-1:0] rsp_data
);
   frspd_host_state_t state_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] data_reg;
   logic write_reg;
   logic rsp_valid_reg;
   logic [DATA_W-1:0] rsp_data_reg;

   assign req_ready = (state_reg == HST_IDLE) && !reset_req;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= HST_IDLE;
         cnt_reg <= '0;
      end else begin
         unique case (state_reg)
            HST_IDLE: begin
               if (reset_req) begin
                  state_reg <= HST_RST;
                  cnt_reg <= CNT_W'(RP_CYC);
               end else if (req_valid) begin
                  state_reg <= HST_ADDR;
               end
            end
            HST_ADDR: begin
               state_reg <= write_reg ? HST_WR : HST_RD;
               cnt_reg <= write_reg ? CNT_W'(WE_CYC - 1) : CNT_W'(RD_CYC - 1);
            end
            HST_WR, HST_RD, HST_RST, HST_REC: begin
               if (cnt_reg != '0) begin
                  cnt_reg <= cnt_reg - 1'b1;
               end else if (state_reg == HST_RST) begin
                  // no reads until the recovery time has passed
                  state_reg <= HST_REC;
                  cnt_reg <= CNT_W'(RH_CYC - 1);
               end else begin
                  state_reg <= (state_reg == HST_REC) ? HST_IDLE : HST_GAP;
               end
            end
            HST_GAP: state_reg <= HST_IDLE;
            default: state_reg <= HST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         addr_reg <= '0;
         data_reg <= '0;
         write_reg <= 1'b0;
      end else if (req_ready && req_valid) begin
         addr_reg <= req_addr;
         data_reg <= req_data;
         write_reg <= req_write;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rsp_valid_reg <= 1'b0;
         rsp_data_reg <= '0;
      end else begin
         rsp_valid_reg <= (state_reg == HST_RD) && (cnt_reg == '0);
         if (state_reg == HST_RD && cnt_reg == '0) begin
            rsp_data_reg <= bus.adq;
         end
      end
   end
   assign rsp_valid = rsp_valid_reg;
   assign rsp_data = rsp_data_reg;

   // output enable stays high through every write so the cycle is accepted
   assign bus.addr_hi = addr_reg[ADDR_W-1:DATA_W];
   assign bus.host_adq_o = (state_reg == HST_ADDR) ? addr_reg[DATA_W-1:0] : data_reg;
   assign bus.host_adq_oe = (state_reg == HST_ADDR) || (state_reg == HST_WR);
   assign bus.avd_n = !(state_reg == HST_ADDR);
   assign bus.ce_n = !(state_reg == HST_ADDR || state_reg == HST_WR || state_reg == HST_RD);
   assign bus.we_n = !(state_reg == HST_WR);
   assign bus.oe_n = !(state_reg == HST_RD);
   assign bus.reset_n = !(state_reg == HST_RST);
endmodule : frspd_host

/* File: tb/frspd_props.sv */
// concurrent checks on the joined flash bus and the flash end status outputs
`timescale 1ns/100ps
module frspd_props
   import frspd_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic dev_adq_oe,
   input wire logic avd_n,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic reset_n,
   input wire logic sleep,
   input wire logic busy,
   input wire logic ready,
   input wire logic prot_refused,
   input wire logic [frspd_pkg::SEC_W-1:0] sector_index,
   input wire logic bank_b
);
   logic [11:0] wait_reg;

   default clocking dclk @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // ready delay runs to 2000 cycles, within the 4096-cycle range of the 12-bit counter
   always_ff @(posedge core_clk) begin
      if (rst || ready) wait_reg <= 12'h000;
      else if (reset_n) wait_reg <= wait_reg + 12'h001;
   end

   a_oe_high_float: assert property (oe_n |-> !dev_adq_oe)
      else $error("bus driven with output enable high");
   a_reset_float: assert property (!reset_n |-> !dev_adq_oe)
      else $error("bus driven during reset pulse");
   a_drive_read_only: assert property (dev_adq_oe |-> !ce_n && !oe_n && we_n && avd_n && reset_n)
      else $error("bus driven outside a read");
   a_sleep_holds: assert property (sleep && avd_n && reset_n |=> sleep)
      else $error("sleep left without new address");
   a_bank_decode: assert property (bank_b == !(sector_index[6] && sector_index[5]))
      else $error("bank flag disagrees with sector");
   a_ready_in_reset: assert property (!reset_n ##1 !reset_n |-> !ready)
      else $error("ready high during reset pulse");
   a_ready_delay: assert property ($rose(reset_n) |-> (!ready && avd_n)[*8])
      else $error("ready or access too soon after reset");
   a_ready_bound: assert property (wait_reg <= 12'(READY_EA_CYC + 4))
      else $error("ready delay too long");
   a_reset_abort: assert property ($rose(reset_n) |=> !busy[*3])
      else $error("operation survived reset");
   a_refuse_idle: assert property (prot_refused |-> !busy ##1 !busy)
      else $error("refused operation started");
endmodule : frspd_props

/* File: tb/flash_reset_protect_sector_decode_tb.sv */
// bench: host and flash ends face each other; read words scored from a queue
`timescale 1ns/100ps
module flash_reset_protect_sector_decode_tb;
   import frspd_pkg::*;
   logic core_clk = 1'h0;
   logic rst = 1'h1;
   logic req_valid = 1'h0;
   logic req_write = 1'h0;
   logic [ADDR_W-1:0] req_addr = '0;
   logic [DATA_W-1:0] req_data = '0;
   logic reset_req = 1'h0;
   logic wp_n = 1'h1;
   logic vpp_n = 1'h1;
   logic supply_low = 1'h0;
   logic req_ready, rsp_valid, sleep, busy, ready, prot_refused, bank_b;
   logic [DATA_W-1:0] rsp_data, d;
   logic [SEC_W-1:0] sector_index;
   logic [DATA_W-1:0] exp_q[$];
   int errors = 0;
   int checks_done = 0;
   int refusals = 0;
   int seed, n, lo;

   frspd_if frspd_if_i ();
   frspd_host frspd_host_i (.core_clk(core_clk), .rst(rst), .bus(frspd_if_i), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
      .reset_req(reset_req), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   frspd_device frspd_device_i (.core_clk(core_clk), .rst(rst), .bus(frspd_if_i), .wp_n(wp_n),
      .vpp_n(vpp_n), .supply_low(supply_low), .sleep(sleep), .busy(busy), .ready(ready),
      .prot_refused(prot_refused), .sector_index(sector_index), .bank_b(bank_b));
   frspd_props frspd_props_i (.core_clk(core_clk), .rst(rst), .dev_adq_oe(frspd_if_i.dev_adq_oe),
      .avd_n(frspd_if_i.avd_n), .ce_n(frspd_if_i.ce_n), .we_n(frspd_if_i.we_n), .oe_n(frspd_if_i.oe_n),
      .reset_n(frspd_if_i.reset_n), .sleep(sleep), .busy(busy), .ready(ready),
      .prot_refused(prot_refused), .sector_index(sector_index), .bank_b(bank_b));

   initial begin
      forever #5 core_clk = ~core_clk;
   end

   task automatic wrap_up();
      if (errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up

   // a wait limit that runs out counts against the run
   task automatic stuck();
      errors++;
      wrap_up();
   endtask : stuck

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic req(input logic wr, input logic [21:0] a, input logic [15:0] dat);
      @(posedge core_clk);
      #1;
      req_valid = 1'h1;
      req_write = wr;
      req_addr = a;
      req_data = dat;
      @(posedge core_clk);
      for (int i = 0; i < 3000 && req_ready !== 1'h1; i++) @(posedge core_clk);
      if (req_ready !== 1'h1) stuck();
      #1;
      req_valid = 1'h0;
   endtask : req

   task automatic rd(input logic [21:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      req(1'h0, a, 16'h0000);
      for (int i = 0; i < 40 && rsp_valid !== 1'h1; i++) @(posedge core_clk) #1;
      if (rsp_valid !== 1'h1) stuck();
   endtask : rd

   task automatic unlock();
      req(1'h1, 22'(UNLOCK_ADDR1), 16'(UNLOCK_DATA1));
      req(1'h1, 22'(UNLOCK_ADDR2), 16'(UNLOCK_DATA2));
   endtask : unlock

   // busy rises a few cycles after the last write is taken
   task automatic settle();
      repeat (8) @(posedge core_clk);
      #1;
      for (int i = 0; i < 3000 && busy !== 1'h0; i++) @(posedge core_clk) #1;
      if (busy !== 1'h0) stuck();
   endtask : settle

   task automatic cmd3(input logic [21:0] a, input logic [7:0] code);
      unlock();
      req(1'h1, a, 16'(code));
      settle();
   endtask : cmd3

   task automatic try_prog(input logic [21:0] a, input logic ok);
      d = 16'($random(seed));
      n = refusals;
      cmd3(22'(UNLOCK_ADDR1), CMD_PROGRAM);
      req(1'h1, a, d);
      settle();
      check(16'(refusals - n), {15'h0000, !ok});
      rd(a, ok ? d : ERASED_WORD);
   endtask : try_prog

   task automatic hw_reset(input int want);
      @(posedge core_clk);
      #1;
      reset_req = 1'h1;
      for (int i = 0; i < 200 && frspd_if_i.reset_n !== 1'h0; i++) @(posedge core_clk) #1;
      if (frspd_if_i.reset_n !== 1'h0) stuck();
      reset_req = 1'h0;
      for (int i = 0; i < 200 && frspd_if_i.reset_n !== 1'h1; i++) @(posedge core_clk) #1;
      if (frspd_if_i.reset_n !== 1'h1) stuck();
      lo = 0;
      for (int i = 0; i < 3000 && ready !== 1'h1; i++) begin
         @(posedge core_clk) #1;
         lo++;
      end
      if (ready !== 1'h1) stuck();
      check(16'(lo >= want - 2 && lo <= want + 2), 16'h0001);
   endtask : hw_reset

   always @(posedge core_clk) begin
      if (prot_refused === 1'h1) refusals++;
      if (rsp_valid === 1'h1 && exp_q.size() == 0) check(rsp_data, 16'hxxxx);
      else if (rsp_valid === 1'h1) check(rsp_data, exp_q.pop_front());
   end

   initial begin
      #(CLK_PERIOD_NS * 40000);
      errors++;
      wrap_up();
   end

   initial begin
      seed = 32'h7871;
      repeat (5) @(posedge core_clk);
      #1;
      rst = 1'h0;
      rd(22'h2F_FFFF, ERASED_WORD);
      check(16'(sector_index), 16'h005F);
      check(16'(bank_b), 16'h0001);
      rd(22'h3F_8000, ERASED_WORD);
      check(16'(sector_index), 16'h007F);
      check(16'(bank_b), 16'h0000);
      check(16'(sleep), 16'h0000);
      repeat (6) @(posedge core_clk) #1;
      check(16'(sleep), 16'h0001);
      rd(22'h3F_8000, ERASED_WORD);
      try_prog(22'h2_8001, 1'h1);
      // program command without its unlock cycles must fall back to array read
      req(1'h1, 22'(UNLOCK_ADDR1), 16'(CMD_PROGRAM));
      req(1'h1, 22'h2_8002, d);
      settle();
      rd(22'h2_8002, ERASED_WORD);
      cmd3(22'h2_8000, CMD_LOCK);
      try_prog(22'h2_8003, 1'h0);
      cmd3(22'h2_8000, CMD_UNLOCK);
      try_prog(22'h2_8003, 1'h1);
      wp_n = 1'h0;
      try_prog(22'h00_0004, 1'h0);
      try_prog(22'h3F_8005, 1'h0);
      try_prog(22'h2_8006, 1'h1);
      wp_n = 1'h1;
      vpp_n = 1'h0;
      try_prog(22'h2_8007, 1'h0);
      vpp_n = 1'h1;
      // a dip mid-sequence must drop the unlock progress
      unlock();
      settle();
      supply_low = 1'h1;
      repeat (4) @(posedge core_clk) #1;
      supply_low = 1'h0;
      repeat (4) @(posedge core_clk) #1;
      req(1'h1, 22'(UNLOCK_ADDR1), 16'(CMD_PROGRAM));
      req(1'h1, 22'h2_8008, d);
      settle();
      rd(22'h2_8008, ERASED_WORD);
      unlock();
      req(1'h1, 22'(UNLOCK_ADDR1), 16'(CMD_ERASE));
      unlock();
      req(1'h1, 22'h2_8000, 16'(CMD_SECTOR_ERASE));
      for (int i = 0; i < 50 && busy !== 1'h1; i++) @(posedge core_clk) #1;
      if (busy !== 1'h1) stuck();
      hw_reset(READY_EA_CYC);
      unlock();
      settle();
      hw_reset(READY_CYC);
      req(1'h1, 22'(UNLOCK_ADDR1), 16'(CMD_PROGRAM));
      req(1'h1, 22'h2_8009, d);
      settle();
      rd(22'h2_8009, ERASED_WORD);
      wrap_up();
   end
endmodule : flash_reset_protect_sector_decode_tb
